// file: bench/eight_bit_reload_event_timer_tb.sv
// testbench for the timer: bus tasks, reference counter model, verdict
// assumes the event source and the monitor are compiled before it
`timescale 1ns/1ps
`default_nettype none
module eight_bit_reload_event_timer_tb;
  import ert_pkg::*;
  logic i_clk = 0, i_arst_n = 0, i_ce = 1;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic [7:0] i_awaddr = 0, i_araddr = 0, ev_n = 0;
  logic [2:0] i_awprot = 0, i_arprot = 0;
  logic [31:0] i_wdata = 0, o_rdata, d, rs = 32'h2f28;
  logic [3:0] i_wstrb = 4'hf;
  logic [1:0] o_bresp, o_rresp, r;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, ev_go = 0, ev_busy;
  logic o_timer_out, o_timer_out_sel, o_overflow_irq_flag;
  wire logic i_event_pin;
  int errors = 0, checks_done = 0, m_cnt = 0, m_rel = 0, m_flag = 0, m_out = 0, m_rl = 0, v;

  always #10 i_clk = ~i_clk;
  ert_timer #(.TCYC_CLKS(1)) i_dut (.*);
  ert_event_src #(.GAP(4)) i_src (.i_clk(i_clk), .i_go(ev_go), .i_n(ev_n),
                                  .o_pin(i_event_pin), .o_busy(ev_busy));

  ////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs

  // entered just after a rising edge; handshakes are judged from negedge samples
  task axw(input logic [7:0] a, input logic [31:0] wv, input logic [1:0] er);
    logic ha, hw, hb;
    i_awaddr <= a;
    i_awvalid <= 1;
    i_wdata <= wv;
    i_wvalid <= 1;
    i_bready <= 1;
    hb = 0;
    while (!hb)
    begin
      @(negedge i_clk);
      ha = i_awvalid && o_awready;
      hw = i_wvalid && o_wready;
      hb = o_bvalid;
      r = o_bresp;
      @(posedge i_clk);
      if (ha) i_awvalid <= 0;
      if (hw) i_wvalid <= 0;
    end
    i_bready <= 0;
    check({hb, r}, {1'b1, er});
    @(posedge i_clk);
  endtask : axw

  task axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] rv);
    logic hr;
    i_araddr <= a;
    i_arvalid <= 1;
    i_rready <= 1;
    hr = 0;
    while (!hr)
    begin
      @(negedge i_clk);
      hr = o_rvalid;
      rv = o_rdata;
      r = o_rresp;
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 0;
    end
    i_rready <= 0;
    check({hr, r}, {1'b1, er});
    @(posedge i_clk);
  endtask : axr

  task rd_cnt();
    axr(8'h4C, ERT_RESP_OKAY, d);
    check(d, m_cnt >> 4);
    axr(8'h48, ERT_RESP_OKAY, d);
    check(d, m_cnt & 15);
  endtask : rd_cnt

  // n pulses from the source; the model advances by k counts
  task ev(input int n, input int k);
    ev_n <= 8'(n);
    ev_go <= 1;
    @(posedge i_clk);
    ev_go <= 0;
    @(negedge i_clk);
    while (ev_busy) @(negedge i_clk);
    repeat (6) @(posedge i_clk);
    repeat (k)
      if (m_cnt == 255)
      begin
        m_cnt = m_rl ? m_rel : 0;
        m_flag = 1;
        m_out ^= 1;
      end
      else m_cnt++;
  endtask : ev

  task load(input int val);
    axw(8'h48, val & 15, ERT_RESP_OKAY);
    axw(8'h4C, val >> 4, ERT_RESP_OKAY);
    m_cnt = val;
    m_rel = val;
  endtask : load

  ////////////////////////////////////////////////////////////
  initial
  begin
    #400000;
    errors++;
    conclude();
  end

  initial
  begin
    repeat (5) @(posedge i_clk);
    i_arst_n <= 1;
    repeat (3) @(posedge i_clk);
    check({o_overflow_irq_flag, o_timer_out_sel, o_timer_out}, 0);
    axr(8'h40, ERT_RESP_OKAY, d);
    check(d, 0);
    axr(8'h9C, ERT_RESP_SLVERR, d);
    axw(8'h9C, 1, ERT_RESP_SLVERR);
    i_ce <= 0;
    @(negedge i_clk);
    check({o_awready, o_arready}, 0);
    @(posedge i_clk);
    i_ce <= 1;
    $display("test reset and map done");
    axw(8'h28, 9, ERT_RESP_OKAY);
    check(o_timer_out_sel, 1);
    axw(8'h40, 15, ERT_RESP_OKAY);
    m_rl = 1;
    repeat (6) @(posedge i_clk);
    axw(8'h48, 14, ERT_RESP_OKAY);
    rd_cnt();
    axw(8'h4C, 15, ERT_RESP_OKAY);
    m_cnt = 254;
    m_rel = 254;
    rd_cnt();
    ev(2, 2);
    check({o_overflow_irq_flag, o_timer_out}, {m_flag[0], m_out[0]});
    rd_cnt();
    axr(8'h80, ERT_RESP_OKAY, d);
    check(d, 1);
    axw(8'h80, 1, ERT_RESP_OKAY);
    axr(8'h80, ERT_RESP_OKAY, d);
    check(d, 0);
    $display("test reload overflow done");
    for (int e = 0; e < 3; e++)
    begin
      rs = xs(rs);
      axw(8'h44, e, ERT_RESP_OKAY);
      load(rs[6:0]);
      ev(3, e == 2 ? 6 : 3);
      rd_cnt();
    end
    axw(8'h4C, 2, ERT_RESP_OKAY);
    m_cnt = 32 | (m_rel & 15);
    rd_cnt();
    $display("test edges done");
    axw(8'h34, 1, ERT_RESP_OKAY);
    ev(3, 0);
    rd_cnt();
    axw(8'h34, 0, ERT_RESP_OKAY);
    ev(1, 2);
    rd_cnt();
    axw(8'h40, 7, ERT_RESP_OKAY);
    m_rl = 0;
    repeat (6) @(posedge i_clk);
    load(255);
    ev(1, 2);
    check({o_overflow_irq_flag, o_timer_out}, {m_flag[0], m_out[0]});
    rd_cnt();
    $display("test standby and free-run done");
    axw(8'h44, 4, ERT_RESP_OKAY);
    check(o_timer_out, m_cnt < m_rel);
    axw(8'h40, 6, ERT_RESP_OKAY);
    repeat (6) @(posedge i_clk);
    load(16);
    repeat (20) @(posedge i_clk);
    // 22 edges from the load to the read, one count per two instruction cycles
    m_cnt += 11;
    rd_cnt();
    $display("test pwm and prescale done");
    conclude();
  end
endmodule : eight_bit_reload_event_timer_tb

bind ert_timer ert_timer_monitor i_mon (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready),
  .o_rdata(o_rdata), .o_rresp(o_rresp), .o_overflow_irq_flag(o_overflow_irq_flag));
`default_nettype wire

// file: bench/ert_event_src.sv
// event source for the timer's event pin: bursts of low pulses on request
// assumes requests only while idle; the pin idles high between bursts
`timescale 1ns/1ps
`default_nettype none
module ert_event_src #(
  parameter int GAP = 4
)(
  // clock and request
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [7:0] i_n,
  // pin and status
  output var logic        o_pin,
  output var logic        o_busy
);
  initial
  begin
    o_pin  = 1'b1;
    o_busy = 1'b0;
  end

  // each level stands GAP clocks, so both-edge counting sees legal spacing
  always @(posedge i_clk)
    if (i_go)
    begin
      o_busy <= 1'b1;
      repeat (i_n)
      begin
        o_pin <= 1'b0;
        repeat (GAP) @(posedge i_clk);
        o_pin <= 1'b1;
        repeat (GAP) @(posedge i_clk);
      end
      o_busy <= 1'b0;
    end
endmodule : ert_event_src
`default_nettype wire

// file: bench/ert_timer_monitor.sv
// bus handshake and flag checks on the top ports of the timer
// assumes single clock domain and the byte map of the package
`timescale 1ns/1ps
`default_nettype none
module ert_timer_monitor
  import ert_pkg::*;
(
  // clock and reset
  input wire logic                  i_clk,
  input wire logic                  i_arst_n,
  input wire logic                  i_ce,
  // write side
  input wire logic                  i_awvalid,
  input wire logic                  o_awready,
  input wire logic [ERT_ADDR_W-1:0] i_awaddr,
  input wire logic                  i_wvalid,
  input wire logic                  o_wready,
  input wire logic                  o_bvalid,
  input wire logic                  i_bready,
  input wire logic [1:0]            o_bresp,
  // read side
  input wire logic                  i_arvalid,
  input wire logic                  o_arready,
  input wire logic [ERT_ADDR_W-1:0] i_araddr,
  input wire logic                  o_rvalid,
  input wire logic                  i_rready,
  input wire logic [31:0]           o_rdata,
  input wire logic [1:0]            o_rresp,
  // flag
  input wire logic                  o_overflow_irq_flag
);
  logic [7:0] aw_reg;
  logic [7:0] aw_next;
  logic [7:0] ar_reg;
  logic [7:0] ar_next;

  always_comb
  begin
    aw_next = (i_awvalid && o_awready) ? i_awaddr : aw_reg;
    ar_next = (i_arvalid && o_arready) ? i_araddr : ar_reg;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      aw_reg <= 8'h00;
      ar_reg <= 8'h00;
    end
    else
    begin
      aw_reg <= aw_next;
      ar_reg <= ar_next;
    end

  function automatic logic [1:0] resp_of(input logic [7:0] a);
    logic [5:0] x;
    x = a[7:2];
    return (x inside {ERT_IDX_PORT_FN, ERT_IDX_STANDBY, ERT_IDX_MODE1, ERT_IDX_MODE2,
                      ERT_IDX_LOW, ERT_IDX_HIGH, ERT_IDX_FLAG}) ? ERT_RESP_OKAY : ERT_RESP_SLVERR;
  endfunction : resp_of

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_read_taken;
    i_arvalid && o_arready;
  endsequence
  sequence s_write_taken;
    i_awvalid && o_awready && i_wvalid && o_wready && !o_bvalid;
  endsequence

  a_read_answer: assert property (s_read_taken |=> o_rvalid && o_rresp == resp_of(ar_reg))
    else $error("read answer late or wrong response");
  a_write_answer: assert property (s_write_taken |=> ##1 (o_bvalid && o_bresp == resp_of(aw_reg)))
    else $error("write answer late or wrong response");
  a_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  a_arready_busy: assert property (o_rvalid |-> !o_arready)
    else $error("read address taken while data pending");
  a_ce_gate: assert property (!i_ce |-> !o_awready && !o_wready && !o_arready)
    else $error("ready high while clock enable low");
  a_rdata_zero: assert property (o_rvalid && o_rresp == ERT_RESP_SLVERR |-> o_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_flag_clear: assert property ($fell(o_overflow_irq_flag) |-> o_bvalid || $past(o_bvalid))
    else $error("flag cleared without a write");
endmodule : ert_timer_monitor
`default_nettype wire

// file: core/ert_timer.sv
// 8-bit up-counting timer: free-running or reload, prescaled or event clock,
// toggle or pwm output, sticky overflow flag, registers over AXI4-Lite
// assumes i_clk at 50 MHz; event pin is asynchronous and synchronised here
`timescale 1ns/1ps
`default_nettype none

module ert_timer
  import ert_pkg::*;
#(
  parameter int TCYC_CLKS = ERT_TCYC_CLKS
)(
  // clock, reset, enable
  input  wire logic                  i_clk,
  input  wire logic                  i_arst_n,
  input  wire logic                  i_ce,
  // axi4-lite write address
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [ERT_ADDR_W-1:0] i_awaddr,
  input  wire logic [2:0]            i_awprot,
  // axi4-lite write data
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  // axi4-lite write response
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  output logic [1:0]                 o_bresp,
  // axi4-lite read address
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  input  wire logic [ERT_ADDR_W-1:0] i_araddr,
  input  wire logic [2:0]            i_arprot,
  // axi4-lite read data
  output logic                       o_rvalid,
  input  wire logic                  i_rready,
  output logic [31:0]                o_rdata,
  output logic [1:0]                 o_rresp,
  // pins
  input  wire logic                  i_event_pin,
  output logic                       o_timer_out,
  output logic                       o_timer_out_sel,
  // overflow request flag level
  output logic                       o_overflow_irq_flag
);

  if (TCYC_CLKS < 1 || TCYC_CLKS > 255)
  begin : g_bad_tcyc
    $error("TCYC_CLKS must lie in 1..255");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release and event synchroniser

  logic rst_q1_reg;
  logic rst_n;
  logic ev_s1_reg;
  logic ev_s2_reg;
  logic ev_s3_reg;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_q1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_q1_reg <= 1'b1;
      rst_n      <= rst_q1_reg;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // pin idles high: a low reset value would fake a rising edge
      ev_s1_reg <= 1'b1;
      ev_s2_reg <= 1'b1;
      ev_s3_reg <= 1'b1;
    end
    else if (i_ce)
    begin
      ev_s1_reg <= i_event_pin;
      ev_s2_reg <= ev_s1_reg;
      ev_s3_reg <= ev_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]  tcyc_cnt_reg,  tcyc_cnt_next;
  logic [10:0] presc_reg,     presc_next;
  logic [3:0]  mode1_reg,     mode1_next;
  logic [3:0]  mode1_pend_reg, mode1_pend_next;
  logic [1:0]  mode1_wait_reg, mode1_wait_next;
  logic [2:0]  mode2_reg,     mode2_next;
  logic [3:0]  port_fn_reg,   port_fn_next;
  logic [1:0]  standby_reg,   standby_next;
  logic [3:0]  reload_lo_reg, reload_lo_next;
  logic [3:0]  reload_hi_reg, reload_hi_next;
  logic [7:0]  count_reg,     count_next;
  logic [3:0]  latch_lo_reg,  latch_lo_next;
  logic [7:0]  duty_reg,      duty_next;
  logic        toggle_reg,    toggle_next;
  logic        flag_reg,      flag_next;
  logic        aw_reg,        aw_next;
  logic [5:0]  aw_idx_reg,    aw_idx_next;
  logic        w_reg,         w_next;
  logic [31:0] wdata_reg,     wdata_next;
  logic        bvalid_reg,    bvalid_next;
  logic [1:0]  bresp_reg,     bresp_next;
  logic        rvalid_reg,    rvalid_next;
  logic [31:0] rdata_reg,     rdata_next;
  logic [1:0]  rresp_reg,     rresp_next;
  logic        out_reg,       out_next;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  logic      tcyc_tick;
  logic      count_tick;
  logic      ev_rise;
  logic      ev_fall;
  logic      overflow;
  logic      do_write;
  logic      do_read;
  logic [5:0] ar_idx;
  ert_edge_t edge_sel;

  always_comb
  begin
    tcyc_cnt_next   = tcyc_cnt_reg;
    presc_next      = presc_reg;
    mode1_next      = mode1_reg;
    mode1_pend_next = mode1_pend_reg;
    mode1_wait_next = mode1_wait_reg;
    mode2_next      = mode2_reg;
    port_fn_next    = port_fn_reg;
    standby_next    = standby_reg;
    reload_lo_next  = reload_lo_reg;
    reload_hi_next  = reload_hi_reg;
    count_next      = count_reg;
    latch_lo_next   = latch_lo_reg;
    duty_next       = duty_reg;
    toggle_next     = toggle_reg;
    flag_next       = flag_reg;
    aw_next         = aw_reg;
    aw_idx_next     = aw_idx_reg;
    w_next          = w_reg;
    wdata_next      = wdata_reg;
    bvalid_next     = bvalid_reg;
    bresp_next      = bresp_reg;
    rvalid_next     = rvalid_reg;
    rdata_next      = rdata_reg;
    rresp_next      = rresp_reg;
    ar_idx          = i_araddr[ERT_ADDR_W-1:2];
    edge_sel        = ert_edge_t'(mode2_reg[1:0]);
    // instruction-cycle tick and the shared divider
    tcyc_tick = (tcyc_cnt_reg == 8'(TCYC_CLKS - 1));
    tcyc_cnt_next = tcyc_tick ? 8'h00 : tcyc_cnt_reg + 8'h01;
    if (tcyc_tick)
      presc_next = presc_reg + 11'h001;
    // event edges from the synchronised copy
    ev_rise = ev_s2_reg & ~ev_s3_reg;
    ev_fall = ~ev_s2_reg & ev_s3_reg;
    // count clock select
    count_tick = 1'b0;
    case (mode1_reg[2:0])
      3'h0: count_tick = tcyc_tick & (&presc_reg[10:0]);
      3'h1: count_tick = tcyc_tick & (&presc_reg[8:0]);
      3'h2: count_tick = tcyc_tick & (&presc_reg[6:0]);
      3'h3: count_tick = tcyc_tick & (&presc_reg[4:0]);
      3'h4: count_tick = tcyc_tick & (&presc_reg[2:0]);
      3'h5: count_tick = tcyc_tick & (&presc_reg[1:0]);
      3'h6: count_tick = tcyc_tick & presc_reg[0];
      ERT_CSEL_EVENT:
      begin
        // pin must be given its event function, else no edges count
        case (edge_sel)
          ERT_EDGE_FALL: count_tick = ev_fall;
          ERT_EDGE_RISE: count_tick = ev_rise;
          default:       count_tick = ev_fall | ev_rise;
        endcase
        count_tick = count_tick & port_fn_reg[ERT_PORT_EVENT_BIT];
      end
    endcase
    // standby gates the counter clock only; registers stay
    count_tick = count_tick & ~standby_reg[ERT_STANDBY_BIT];
    // counting and overflow
    overflow = count_tick && (count_reg == ERT_COUNT_MAX);
    if (count_tick)
    begin
      if (overflow)
      begin
        if (mode1_reg[ERT_MODE1_RELOAD_BIT])
          count_next = {reload_hi_reg, reload_lo_reg};
        else
          count_next = ERT_COUNT_ZERO;
        toggle_next = ~toggle_reg;
        duty_next   = {reload_hi_reg, reload_lo_reg};
      end
      else
        count_next = count_reg + 8'h01;
    end
    // delayed mode-one update: two instruction cycles after the write
    if (mode1_wait_reg != 2'h0 && tcyc_tick)
    begin
      mode1_wait_next = mode1_wait_reg - 2'h1;
      if (mode1_wait_reg == 2'h1)
        mode1_next = mode1_pend_reg;
    end
    // write channel: address and data taken in either order
    if (i_awvalid && !aw_reg)
    begin
      aw_next     = 1'b1;
      aw_idx_next = i_awaddr[ERT_ADDR_W-1:2];
    end
    if (i_wvalid && !w_reg)
    begin
      w_next     = 1'b1;
      wdata_next = i_wdata;
    end
    do_write = aw_reg && w_reg && !bvalid_reg;
    if (do_write)
    begin
      aw_next     = 1'b0;
      w_next      = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = ERT_RESP_OKAY;
      if (aw_idx_reg == ERT_IDX_MODE1)
      begin
        mode1_pend_next = wdata_reg[3:0];
        mode1_wait_next = 2'(ERT_MODE_DELAY_INSTR);
      end
      else if (aw_idx_reg == ERT_IDX_MODE2)
        mode2_next = wdata_reg[2:0];
      else if (aw_idx_reg == ERT_IDX_LOW)
        reload_lo_next = wdata_reg[3:0];
      else if (aw_idx_reg == ERT_IDX_HIGH)
      begin
        reload_hi_next = wdata_reg[3:0];
        count_next     = {wdata_reg[3:0], reload_lo_reg};
        if (mode1_reg[ERT_MODE1_RELOAD_BIT])
          duty_next = {wdata_reg[3:0], reload_lo_reg};
      end
      else if (aw_idx_reg == ERT_IDX_PORT_FN)
        port_fn_next = wdata_reg[3:0];
      else if (aw_idx_reg == ERT_IDX_STANDBY)
        standby_next = wdata_reg[1:0];
      else if (aw_idx_reg == ERT_IDX_FLAG)
        flag_next = flag_reg & ~wdata_reg[ERT_FLAG_BIT];
      else
        bresp_next = ERT_RESP_SLVERR;
    end
    if (bvalid_reg && i_bready)
      bvalid_next = 1'b0;
    // set wins over a clear in the same cycle
    if (overflow)
      flag_next = 1'b1;
    // read channel
    do_read = i_arvalid && !rvalid_reg;
    if (do_read)
    begin
      rvalid_next = 1'b1;
      rresp_next  = ERT_RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      if (ar_idx == ERT_IDX_HIGH)
      begin
        rdata_next[3:0] = count_reg[7:4];
        latch_lo_next   = count_reg[3:0];
      end
      else if (ar_idx == ERT_IDX_LOW)
        rdata_next[3:0] = latch_lo_reg;
      else if (ar_idx == ERT_IDX_FLAG)
        rdata_next[ERT_FLAG_BIT] = flag_reg;
      else if (ar_idx == ERT_IDX_MODE1 || ar_idx == ERT_IDX_MODE2 ||
               ar_idx == ERT_IDX_PORT_FN || ar_idx == ERT_IDX_STANDBY)
        rdata_next = 32'h0000_0000;
      else
        rresp_next = ERT_RESP_SLVERR;
    end
    if (rvalid_reg && i_rready)
      rvalid_next = 1'b0;
    // output waveform
    if (mode2_reg[ERT_MODE2_PWM_BIT])
      out_next = (count_reg < duty_reg);
    else
      out_next = toggle_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tcyc_cnt_reg   <= 8'h00;
      presc_reg      <= 11'h000;
      mode1_reg      <= ERT_MODE1_RST;
      mode1_pend_reg <= ERT_MODE1_RST;
      mode1_wait_reg <= 2'h0;
      mode2_reg      <= ERT_MODE2_RST;
      port_fn_reg    <= ERT_PORT_RST;
      standby_reg    <= ERT_STANDBY_RST;
      reload_lo_reg  <= ERT_LOW_RST;
      reload_hi_reg  <= 4'h0;
      count_reg      <= ERT_COUNT_ZERO;
      latch_lo_reg   <= 4'h0;
      duty_reg       <= ERT_COUNT_ZERO;
      toggle_reg     <= 1'b0;
      flag_reg       <= 1'b0;
      aw_reg         <= 1'b0;
      aw_idx_reg     <= 6'h00;
      w_reg          <= 1'b0;
      wdata_reg      <= 32'h0000_0000;
      bvalid_reg     <= 1'b0;
      bresp_reg      <= ERT_RESP_OKAY;
      rvalid_reg     <= 1'b0;
      rdata_reg      <= 32'h0000_0000;
      rresp_reg      <= ERT_RESP_OKAY;
      out_reg        <= 1'b0;
    end
    else if (i_ce)
    begin
      tcyc_cnt_reg   <= tcyc_cnt_next;
      presc_reg      <= presc_next;
      mode1_reg      <= mode1_next;
      mode1_pend_reg <= mode1_pend_next;
      mode1_wait_reg <= mode1_wait_next;
      mode2_reg      <= mode2_next;
      port_fn_reg    <= port_fn_next;
      standby_reg    <= standby_next;
      reload_lo_reg  <= reload_lo_next;
      reload_hi_reg  <= reload_hi_next;
      count_reg      <= count_next;
      latch_lo_reg   <= latch_lo_next;
      duty_reg       <= duty_next;
      toggle_reg     <= toggle_next;
      flag_reg       <= flag_next;
      aw_reg         <= aw_next;
      aw_idx_reg     <= aw_idx_next;
      w_reg          <= w_next;
      wdata_reg      <= wdata_next;
      bvalid_reg     <= bvalid_next;
      bresp_reg      <= bresp_next;
      rvalid_reg     <= rvalid_next;
      rdata_reg      <= rdata_next;
      rresp_reg      <= rresp_next;
      out_reg        <= out_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; ready terms are held low while the clock enable is low
  assign o_awready           = i_ce & ~aw_reg;
  assign o_wready            = i_ce & ~w_reg;
  assign o_bvalid            = bvalid_reg;
  assign o_bresp             = bresp_reg;
  assign o_arready           = i_ce & ~rvalid_reg;
  assign o_rvalid            = rvalid_reg;
  assign o_rdata             = rdata_reg;
  assign o_rresp             = rresp_reg;
  assign o_timer_out         = out_reg;
  assign o_timer_out_sel     = port_fn_reg[ERT_PORT_OUT_BIT];
  assign o_overflow_irq_flag = flag_reg;
  logic unused_ok;
  assign unused_ok = ^{i_awprot, i_arprot, i_wstrb, standby_reg[1]};

endmodule : ert_timer

`default_nettype wire

// file: include/ert_pkg.sv
// package for the 8-bit reload/event timer: register map, fields, reset values, timing
// assumes a 32-bit AXI4-Lite slave with each register at byte address = index * 4
package ert_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] ERT_IDX_PORT_FN = 6'h0A;
  localparam logic [5:0] ERT_IDX_STANDBY = 6'h0D;
  localparam logic [5:0] ERT_IDX_MODE1   = 6'h10;
  localparam logic [5:0] ERT_IDX_MODE2   = 6'h11;
  localparam logic [5:0] ERT_IDX_LOW     = 6'h12;
  localparam logic [5:0] ERT_IDX_HIGH    = 6'h13;
  localparam logic [5:0] ERT_IDX_FLAG    = 6'h20;
  localparam int         ERT_ADDR_W      = 8;

  // field positions
  localparam int ERT_MODE1_RELOAD_BIT = 3;
  localparam int ERT_MODE2_PWM_BIT    = 2;
  localparam int ERT_PORT_EVENT_BIT   = 0;
  localparam int ERT_PORT_OUT_BIT     = 3;
  localparam int ERT_STANDBY_BIT      = 0;
  localparam int ERT_FLAG_BIT         = 0;

  // reset values and count limits
  localparam logic [3:0] ERT_MODE1_RST   = 4'h0;
  localparam logic [2:0] ERT_MODE2_RST   = 3'h0;
  localparam logic [3:0] ERT_LOW_RST     = 4'h0;
  localparam logic [3:0] ERT_PORT_RST    = 4'h0;
  localparam logic [1:0] ERT_STANDBY_RST = 2'h0;
  localparam logic [7:0] ERT_COUNT_MAX   = 8'hFF;
  localparam logic [7:0] ERT_COUNT_ZERO  = 8'h00;

  // count clock selection
  localparam logic [2:0] ERT_CSEL_EVENT = 3'h7;

  // timing: one instruction cycle and the mode-one settle delay
  localparam int ERT_CLK_NS          = 20;
  localparam int ERT_TCYC_NS         = 80;
  localparam int ERT_TCYC_CLKS       = (ERT_TCYC_NS + ERT_CLK_NS - 1) / ERT_CLK_NS;
  localparam int ERT_MODE_DELAY_INSTR = 2;

  // axi response codes
  localparam logic [1:0] ERT_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ERT_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ERT_EDGE_FALL,
    ERT_EDGE_RISE,
    ERT_EDGE_BOTH,
    ERT_EDGE_BOTH_ALT
  } ert_edge_t;

endpackage : ert_pkg
